// >>> hall_switch_consts.svh
// Constants for the programmable switch-point block: register offsets,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name from the switch-point design file; the package does not include it.
`ifndef HALL_SWITCH_CONSTS_SVH
`define HALL_SWITCH_CONSTS_SVH

// Clock rate in MHz and in Hz.
`define CLK_MHZ          10
`define CLK_HZ           10000000

// Chopper clock frequency in Hz.
`define CHOP_HZ          340000

// Least raised time of an enable, address or lock pulse, in microseconds.
`define PULSE_ON_US      20
// Least time between pulses at the base level, in microseconds.
`define PULSE_OFF_US     20
// Least high-level time of a bit-burning pulse, in microseconds.
`define BURN_ON_US       100

// Least count of mid-level pulses in the enable sequence.
`define ENABLE_MID_MIN   7
// Trial address that burns the lock instead of an address bit.
`define LOCK_SELECT      7

// Register byte offsets.
`define REG_BASE_THR     4'h0
`define REG_CONFIG       4'h4
`define REG_STATUS       4'h8
`define REG_FIELD        4'hc

// Field positions in the configuration register.
`define CFG_STEP_LSB     0
`define CFG_HYST_LSB     8

// Field positions in the status register.
`define ST_ON_BIT        0
`define ST_MODE_LSB      1
`define ST_LOCK_BIT      3
`define ST_FUSE_LSB      4
`define ST_TRIAL_LSB     10

// Reset values of writable registers.
`define BASE_THR_RESET   12'h014
`define STEP_RESET       8'h0b
`define HYST_RESET       8'h14

`endif

// >>> hall_switch_pkg.sv
// Types shared by the programmable switch-point block.
// Assumes nothing of its surroundings.
package hall_switch_pkg;

  // Supply level as seen by the level comparators.
  typedef enum logic [1:0] {
    lv_off,
    lv_base,
    lv_mid,
    lv_high
  } level_t;

  // Program-mode sequencer states.
  typedef enum logic [1:0] {
    st_idle,
    st_armed,
    st_addressing,
    st_spent
  } prog_state_t;

endpackage : hall_switch_pkg

// >>> pin_sync.sv
// Two-stage synchroniser for inputs that arrive from outside the clock domain.
// Assumes the receiving logic reads only the second stage.
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // Asynchronous input and its synchronised copy.
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second, so metastability never fans out.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : pin_sync

`default_nettype wire

// >>> supply_programmer.sv
// Behavioural model of the programming fixture that drives the supply pin.
// Assumes one request at a time: start is high for one cycle and done answers it.
`timescale 1ns/1ns
`default_nettype none

module supply_programmer #(
  parameter int GAP = 250
) (
  // Clock.
  input  wire logic        clk_in,
  // Request from the bench.
  input  wire logic        start_in,
  input  wire logic [1:0]  level_in,
  input  wire logic [15:0] on_cycles_in,
  // Supply pin and completion.
  output var  logic [1:0]  supply_level_out,
  output var  logic        done_out
);
  // One pulse per request: raise, hold, return to base, then rest before done.
  // The supply is always driven, so the pin never floats between pulses.
  initial begin
    supply_level_out = 2'h1;
    done_out = 1'b0;
    forever begin
      @(posedge clk_in);
      done_out <= 1'b0;
      if (start_in) begin
        supply_level_out <= level_in;
        repeat (on_cycles_in) @(posedge clk_in);
        supply_level_out <= 2'h1;
        repeat (GAP) @(posedge clk_in);
        done_out <= 1'b1;
      end
    end
  end
endmodule : supply_programmer

`default_nettype wire

// >>> switch_point_program_logic.sv
// Programmable threshold switch: chopper sampling, hysteresis output stage,
// supply-line program sequencer and an Avalon-MM register slave.
// Assumes comparator and converter pins asynchronous to clk_in.
`timescale 1ns/1ns
`default_nettype none

`include "hall_switch_consts.svh"

// What this block does
// - Output goes low when the field rises above the operate threshold.
// - Output returns high only when the field falls below release threshold.
// - Hysteresis band is the same for every switch-point address.
// - Programming runs serially over supply level pulses only, no data pin.
// - Addressing mode needs high pulse, at least seven mid pulses, high pulse.
// - Three supply levels are symbols: base, mid and high programming level.
// - Sixty-four switch-point settings are selectable one after another.
// - Address is a 6-bit code, each bit burned alone, numbered from 1.
// - A long high pulse burns an address bit permanently.
// - Once the lock is burned every later program sequence is ignored.
// - A chopper clock reverses sensing and sample-and-hold cancels offset.
module switch_point_program_logic
  import hall_switch_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Supply level comparators and field converter.
  input  wire logic [1:0]  supply_level_in,
  input  wire logic [11:0] field_raw_in,
  // Switch output and chopper drive.
  output var  logic        switch_n_out,
  output var  logic        chop_phase_out,
  // Avalon-MM slave.
  input  wire logic [3:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output var  logic [31:0] readdata_out,
  output var  logic        waitrequest_out
);

  // Cycle counts derived from the printed times; pulse and burn counts are exact at 10 MHz, the chopper half period truncates to 14 cycles.
  localparam int PULSE_MIN_CYC = `PULSE_ON_US * `CLK_MHZ;
  localparam int BURN_CYC      = `BURN_ON_US * `CLK_MHZ;
  localparam int CHOP_HALF_CYC = `CLK_HZ / (2 * `CHOP_HZ);
  localparam logic [10:0] PULSE_MIN = 11'(PULSE_MIN_CYC);
  localparam logic [10:0] BURN_LAST = 11'(BURN_CYC - 1);
  localparam logic [4:0]  CHOP_LAST = 5'(CHOP_HALF_CYC - 1);

  // Synchronised pins.
  logic [1:0]  level_sync;
  logic [11:0] raw_sync;

  pin_sync #(.WIDTH(2)) u_level_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in (supply_level_in),
    .sync_out (level_sync)
  );

  pin_sync #(.WIDTH(12)) u_raw_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in (field_raw_in),
    .sync_out (raw_sync)
  );

  // Supply symbols decoded from the comparator code.
  level_t level;
  wire    lvl_off    = (level == lv_off);
  wire    lvl_base   = (level == lv_base);
  wire    lvl_high   = (level == lv_high);
  wire    lvl_raised = (level == lv_mid) || lvl_high;
  assign  level      = level_t'(level_sync);

  // Chopper divider, phase and the two sample-and-hold values.
  logic [4:0]         chop_cnt;
  logic signed [11:0] hold_pos;
  logic signed [11:0] hold_neg;
  wire                chop_tick = (chop_cnt == CHOP_LAST);

  // Each phase is sampled at its end, after the plate has settled.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chop_cnt       <= 5'h00;
      chop_phase_out <= 1'b0;
      hold_pos       <= 12'sh000;
      hold_neg       <= 12'sh000;
    end else begin
      chop_cnt <= chop_tick ? 5'h00 : chop_cnt + 5'h01;
      if (chop_tick) begin
        chop_phase_out <= ~chop_phase_out;
        if (chop_phase_out)
          hold_neg <= signed'(raw_sync);
        else
          hold_pos <= signed'(raw_sync);
      end
    end
  end

  // The signal flips sign with the current, the offset does not, so the
  // half difference keeps the field and drops the offset.
  wire signed [12:0] chop_diff = 13'(hold_pos) - 13'(hold_neg);
  wire signed [11:0] field     = 12'(chop_diff >>> 1);

  // Writable configuration.
  logic [11:0] base_thr;
  logic [7:0]  step;
  logic [7:0]  hyst;

  // Sequencer state, pulse measurement and fuses.
  prog_state_t state;
  prog_state_t next_state;
  logic [10:0] pulse_cnt;
  logic        peak_high;
  logic        was_raised;
  logic [2:0]  mid_cnt;
  logic [5:0]  trial;
  logic [5:0]  fuse;
  logic        lock;

  // A pulse is judged when the supply drops back to base.
  wire pulse_end  = was_raised && lvl_base;
  wire pulse_ok   = pulse_end && (pulse_cnt >= PULSE_MIN);
  wire ok_mid     = pulse_ok && !peak_high;
  wire ok_high    = pulse_ok && peak_high;
  wire enough_mid = (mid_cnt >= 3'(`ENABLE_MID_MIN));

  // Burning fires once, the cycle a high pulse reaches its least width.
  wire burn_now   = (state == st_addressing) && lvl_high && (pulse_cnt == BURN_LAST);
  wire burn_bit   = burn_now && (trial >= 6'h01) && (trial <= 6'h06);
  wire burn_lock  = burn_now && (trial == 6'(`LOCK_SELECT));
  wire [5:0] burn_mask = burn_bit ? 6'(6'h01 << (trial - 6'h01)) : 6'h00;

  // Sequencer next state.
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (ok_high && !lock)
          next_state = st_armed;
      end
      st_armed: begin
        if (ok_high)
          next_state = enough_mid ? st_addressing : st_idle;
      end
      st_addressing: begin
        if (burn_now)
          next_state = st_spent;
        else if (ok_high)
          next_state = st_idle;
      end
      st_spent: begin
        if (pulse_end)
          next_state = st_idle;
      end
      default: next_state = st_idle;
    endcase
    if (lvl_off || lock)
      next_state = st_idle;
  end

  // Pulse width counter and peak level, measured from the supply alone.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pulse_cnt  <= 11'h000;
      peak_high  <= 1'b0;
      was_raised <= 1'b0;
    end else begin
      was_raised <= lvl_raised;
      if (!lvl_raised) begin
        pulse_cnt <= 11'h000;
        peak_high <= 1'b0;
      end else begin
        if (pulse_cnt != 11'h7ff)
          pulse_cnt <= pulse_cnt + 11'h001;
        if (lvl_high)
          peak_high <= 1'b1;
      end
    end
  end

  // Sequencer registers. Short glitches below the least pulse width are
  // ignored, which trades a little speed for noise immunity on the supply.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state   <= st_idle;
      mid_cnt <= 3'h0;
      trial   <= 6'h00;
    end else begin
      state <= next_state;
      if (next_state != st_armed)
        mid_cnt <= 3'h0;
      else if (ok_mid && !enough_mid)
        mid_cnt <= mid_cnt + 3'h1;
      if (state != st_addressing)
        trial <= 6'h00;
      else if (ok_mid && next_state == st_addressing)
        trial <= trial + 6'h01;
    end
  end

  // Fuse cells only ever set; the reset value stands for an unburned part.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fuse <= 6'h00;
      lock <= 1'b0;
    end else begin
      fuse <= fuse | burn_mask;
      if (burn_lock)
        lock <= 1'b1;
    end
  end

  // The trial address steers the threshold only in addressing mode.
  wire [5:0]         sel_addr = (state == st_addressing) ? trial : fuse;
  wire [13:0]        op_thr   = 14'(base_thr) + 14'(sel_addr * step);
  wire signed [14:0] op_s     = signed'({1'b0, op_thr});
  wire signed [14:0] rel_s    = op_s - signed'(15'(hyst));
  wire signed [14:0] field_s  = 15'(field);
  wire               above_op  = field_s > op_s;
  wire               below_rel = field_s < rel_s;

  // Output stage with hysteresis: low means on.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      switch_n_out <= 1'b1;
    end else begin
      if (above_op)
        switch_n_out <= 1'b0;
      else if (below_rel)
        switch_n_out <= 1'b1;
    end
  end

  // Avalon decode. A request is answered on the second edge after it rises.
  wire        req      = read_in || write_in;
  wire        accept   = req && !waitrequest_out;
  wire        hit_base = (address_in == `REG_BASE_THR);
  wire        hit_cfg  = (address_in == `REG_CONFIG);
  wire [31:0] cfg_word = {16'h0000, hyst, step};
  wire [31:0] st_word  = {16'h0000, trial, fuse, lock, 2'(state), ~switch_n_out};
  wire [31:0] rd_sel   = hit_base ? {20'h00000, base_thr} :
                         hit_cfg  ? cfg_word :
                         (address_in == `REG_STATUS) ? st_word :
                         (address_in == `REG_FIELD)  ? 32'(field) : 32'h00000000;

  // Bus handshake and read data; unmapped reads give zero.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      waitrequest_out <= 1'b1;
      readdata_out    <= 32'h00000000;
    end else begin
      waitrequest_out <= !(req && waitrequest_out);
      if (req && waitrequest_out)
        readdata_out <= rd_sel;
    end
  end

  // Writable registers commit only at the edge where waitrequest is seen low.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      base_thr <= `BASE_THR_RESET;
      step     <= `STEP_RESET;
      hyst     <= `HYST_RESET;
    end else if (accept && write_in) begin
      if (hit_base)
        base_thr <= writedata_in[11:0];
      if (hit_cfg) begin
        step <= writedata_in[`CFG_STEP_LSB +: 8];
        hyst <= writedata_in[`CFG_HYST_LSB +: 8];
      end
    end
  end

  // Checks.
  a_out_on_above: assert property (@(posedge clk_in) disable iff (!nrst_in)
    above_op |=> !switch_n_out) else $error("output not on above operate point");

  a_out_off_below: assert property (@(posedge clk_in) disable iff (!nrst_in)
    below_rel && !above_op |=> switch_n_out) else $error("output not off below release point");

  a_band_holds: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !above_op && !below_rel |=> $stable(switch_n_out)) else $error("output moved inside band");

  a_hyst_const: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (op_s - rel_s) == signed'(15'(hyst))) else $error("hysteresis depends on address");

  a_enable_seq: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(state == st_addressing) |-> $past(state) == st_armed && $past(mid_cnt) >= 3'h7)
    else $error("addressing mode entered without full enable sequence");

  a_off_drops: assert property (@(posedge clk_in) disable iff (!nrst_in)
    lvl_off |=> state == st_idle) else $error("supply interruption did not end sequence");

  a_trial_step: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state == st_addressing && ok_mid && !lvl_off && !lock |=> trial == $past(trial) + 6'h01)
    else $error("trial address did not advance");

  a_fuse_sticky: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ($past(fuse) & ~fuse) == 6'h00) else $error("burned bit was cleared");

  a_burn_width: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fuse != $past(fuse) |-> $past(pulse_cnt) == BURN_LAST && $past(lvl_high))
    else $error("bit burned without full-width high pulse");

  a_lock_blocks: assert property (@(posedge clk_in) disable iff (!nrst_in)
    lock |=> state == st_idle) else $error("sequence accepted after lock");

  a_chop_tick: assert property (@(posedge clk_in) disable iff (!nrst_in)
    chop_phase_out != $past(chop_phase_out) |-> $past(chop_cnt) == CHOP_LAST)
    else $error("chopper phase changed off its period");

  a_hold_sample: assert property (@(posedge clk_in) disable iff (!nrst_in)
    chop_tick && !chop_phase_out |=> hold_pos == $past(raw_sync))
    else $error("positive phase hold missed its sample");

  a_short_ignored: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pulse_end && !pulse_ok && state != st_spent |=> state == $past(state))
    else $error("pulse below least width changed the sequence");

  a_mid_count: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state == st_armed && ok_mid && !enough_mid |=> mid_cnt == $past(mid_cnt) + 3'h1)
    else $error("mid pulse not counted while armed");

  a_trial_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state != st_addressing |=> trial == 6'h00)
    else $error("trial address not restarted from zero");

  a_one_bit: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fuse != $past(fuse) |-> $onehot(fuse ^ $past(fuse)))
    else $error("more than one address bit burned at once");

  a_lock_select: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(lock) |-> $past(state) == st_addressing && $past(trial) == 6'(`LOCK_SELECT))
    else $error("lock burned outside its selection");

endmodule : switch_point_program_logic

`default_nettype wire

// >>> tb_switch_point_program_logic.sv
// Self-checking bench for the switch-point block: registers, hysteresis and programming.
// Assumes the supply programmer model drives the supply pin and the bench drives the field.
`timescale 1ns/1ns
`default_nettype none

module tb_switch_point_program_logic;
  logic              clk_in = 1'b0;
  logic              nrst_in = 1'b0;
  logic              read_in = 1'b0;
  logic              write_in = 1'b0;
  logic [3:0]        address_in = 4'h0;
  logic [31:0]       writedata_in = 32'h0;
  logic [31:0]       readdata_out;
  logic              waitrequest_out, switch_n_out, chop_phase_out;
  logic [1:0]        supply_level_in;
  logic [11:0]       field_raw_in = 12'h030;
  logic signed [11:0] field_val = 12'sh000;
  logic              pg_start = 1'b0;
  logic              pg_done;
  logic [1:0]        pg_level = 2'h1;
  logic [15:0]       pg_len = 16'h0;
  int                fail_count = 0;
  int                check_count = 0;

  // The clock runs at 10 MHz.
  always #50 clk_in = ~clk_in;

  // Chopped raw reading with a fixed offset that the sampling must cancel.
  always @(posedge clk_in) field_raw_in <= chop_phase_out ? 12'h030 - field_val : 12'h030 + field_val;

  switch_point_program_logic dut_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .supply_level_in(supply_level_in), .field_raw_in(field_raw_in),
    .switch_n_out(switch_n_out), .chop_phase_out(chop_phase_out), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out));

  supply_programmer prog_u (
    .clk_in(clk_in), .start_in(pg_start), .level_in(pg_level), .on_cycles_in(pg_len),
    .supply_level_out(supply_level_in), .done_out(pg_done));

  // Comparison and reporting.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // One bus cycle; the extra edge at the end keeps strobes from being set twice in one step.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    address_in <= a;
    writedata_in <= d;
    read_in <= !wr;
    write_in <= wr;
    do @(posedge clk_in); while (waitrequest_out !== 1'b0);
    q = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus

  task automatic rchk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & mask, exp);
  endtask : rchk

  // Supply pulses through the programmer model.
  task automatic pulse(input logic [1:0] lvl, input logic [15:0] len);
    pg_level <= lvl;
    pg_len <= len;
    pg_start <= 1'b1;
    @(posedge clk_in);
    pg_start <= 1'b0;
    do @(posedge clk_in); while (pg_done !== 1'b1);
  endtask : pulse

  task automatic enable(input int nmid);
    pulse(2'h3, 16'd250);
    repeat (nmid) pulse(2'h2, 16'd250);
    pulse(2'h3, 16'd250);
  endtask : enable

  task automatic burn(input int trial);
    enable(7);
    repeat (trial) pulse(2'h2, 16'd250);
    pulse(2'h3, 16'd1100);
  endtask : burn

  // Field is applied, left to pass sync, chop phases and output stage, then the output judged.
  task automatic field(input logic signed [11:0] f, input logic exp_n);
    field_val <= f;
    repeat (60) @(posedge clk_in);
    check({31'h0, switch_n_out}, {31'h0, exp_n});
  endtask : field

  task automatic t_regs;
    logic [31:0] q;
    rchk(4'h0, 32'hffffffff, 32'h00000014);
    rchk(4'h4, 32'hffffffff, 32'h0000140b);
    rchk(4'h8, 32'h000003ff, 32'h0);
    bus(1'b1, 4'h8, 32'hffffffff, q);
    rchk(4'h8, 32'h000003fe, 32'h0);
    bus(1'b1, 4'h2, 32'h00000055, q);
    rchk(4'h2, 32'hffffffff, 32'h0);
    bus(1'b1, 4'h0, 32'h00000123, q);
    rchk(4'h0, 32'hffffffff, 32'h00000123);
    bus(1'b1, 4'h0, 32'h00000014, q);
  endtask : t_regs

  // Address 0: operate at 20, release at 0.
  task automatic t_hyst;
    field(12'sd21, 1'b0);
    rchk(4'h8, 32'h00000001, 32'h1);
    field(12'sd10, 1'b0);
    rchk(4'hc, 32'hffffffff, 32'h0000000a);
    field(-12'sd1, 1'b1);
    rchk(4'hc, 32'hffffffff, 32'hffffffff);
    field(12'sd10, 1'b1);
  endtask : t_hyst

  task automatic t_chop;
    logic p;
    int   n;
    p = chop_phase_out;
    n = 0;
    while (chop_phase_out === p && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    p = chop_phase_out;
    n = 0;
    while (chop_phase_out === p && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    check(n, 32'd14);
  endtask : t_chop

  // Too few mid pulses, or a supply dropout, must leave programming shut.
  task automatic t_refuse;
    enable(6);
    rchk(4'h8, 32'h00000006, 32'h0);
    pulse(2'h3, 16'd250);
    repeat (4) pulse(2'h2, 16'd250);
    pulse(2'h0, 16'd50);
    repeat (4) pulse(2'h2, 16'd250);
    pulse(2'h3, 16'd250);
    rchk(4'h8, 32'h00000006, 32'h2);
    // A mid pulse below the least width must not count towards the seven.
    repeat (6) pulse(2'h2, 16'd250);
    pulse(2'h2, 16'd150);
    pulse(2'h3, 16'd250);
    rchk(4'h8, 32'h00000006, 32'h0);
  endtask : t_refuse

  // Trial 5: operate at 75, release at 55, the same band as address 0.
  task automatic t_address;
    enable(7);
    rchk(4'h8, 32'h0000fc06, 32'h00000004);
    repeat (5) pulse(2'h2, 16'd250);
    rchk(4'h8, 32'h0000fc00, 32'h00001400);
    field(12'sd60, 1'b1);
    field(12'sd76, 1'b0);
    field(12'sd56, 1'b0);
    field(12'sd54, 1'b1);
    pulse(2'h3, 16'd250);
    rchk(4'h8, 32'h00000006, 32'h0);
  endtask : t_address

  // Address 5 is burned as bits 1 and 3, then locked.
  task automatic t_burn_lock;
    burn(1);
    rchk(4'h8, 32'h000003f6, 32'h00000010);
    burn(3);
    rchk(4'h8, 32'h000003f6, 32'h00000050);
    field(12'sd76, 1'b0);
    field(12'sd54, 1'b1);
    burn(7);
    rchk(4'h8, 32'h000003fe, 32'h00000058);
    enable(7);
    rchk(4'h8, 32'h00000006, 32'h0);
    burn(2);
    rchk(4'h8, 32'h000003fe, 32'h00000058);
  endtask : t_burn_lock

  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_hyst();
    t_chop();
    t_refuse();
    t_address();
    t_burn_lock();
    report_and_stop();
  end

  // Watchdog set well above the roughly 60000 cycles the sequence needs.
  initial begin
    repeat (90000) @(posedge clk_in);
    fail_count++;
    report_and_stop();
  end
endmodule : tb_switch_point_program_logic

`default_nettype wire
